/* logic/ita_top.sv */
// Purpose: I2C target giving access to virtual inputs and PWM duty bytes
// Assumes: SCL well below clock_i/8, open-drain SDA resolved outside
// Notes: Only block 0 holds registers; other addresses read as zero
module ita_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Configuration
  input wire logic [3:0] ctrl_code_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Controlled outputs
  output logic output_state_zero_o,
  output logic output_state_one_o,
  output logic switched_output_en_o,
  output logic [15:0] pwm_duty_o
);
  import ita_pkg::*;

  ita_core_s st_ff;
  ita_core_s nxt_st;
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic code_ok;
  logic wr_commit;
  logic [7:0] rd_byte;

  ita_sync u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({scl_i, sda_i}),
    .pin_sync_o(pins_s)
  );

  function automatic ita_sel_e addr_sel(input logic [10:0] a);
    if (a == ADDR_DUTY_LO) begin
      return SEL_DUTY_LO;
    end else if (a == ADDR_DUTY_HI) begin
      return SEL_DUTY_HI;
    end else if (a == ADDR_VIN) begin
      return SEL_VIN;
    end else begin
      return SEL_NONE;
    end
  endfunction

  function automatic logic [7:0] read_byte(input logic [10:0] a,
                                           input ita_regs_s r);
    case (addr_sel(a))
      SEL_DUTY_LO: return r.duty_lo;
      SEL_DUTY_HI: return r.duty_hi;
      SEL_VIN: return {6'h00, r.vin};
      default: return UNMAPPED_RD;
    endcase
  endfunction

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~st_ff.scl_q;
  assign scl_fall = ~scl_s & st_ff.scl_q;
  // SDA moves only while SCL is high for start and stop
  assign bus_start = scl_s & st_ff.scl_q & st_ff.sda_q & ~sda_s;
  assign bus_stop = scl_s & st_ff.scl_q & ~st_ff.sda_q & sda_s;
  assign byte_done = scl_fall & (st_ff.cnt == BYTE_BITS);
  assign code_ok = st_ff.shift[CB_CODE_MSB:CB_CODE_LSB] == ctrl_code_i;
  assign wr_commit = (st_ff.state == ST_WDATA) & byte_done;
  assign rd_byte = read_byte(st_ff.addr, st_ff.regs);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_q = scl_s;
    nxt_st.sda_q = sda_s;
    if (bus_start) begin
      // Address stays loaded for the read that follows
      nxt_st.state = ST_CTRL;
      nxt_st.cnt = 4'h0;
      nxt_st.drive = 1'b0;
    end else if (bus_stop) begin
      nxt_st.state = ST_IDLE;
      nxt_st.drive = 1'b0;
    end else begin
      case (st_ff.state)
        ST_CTRL, ST_WADDR, ST_WDATA: begin
          if (scl_rise && st_ff.cnt != BYTE_BITS) begin
            nxt_st.shift = {st_ff.shift[6:0], sda_s};
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end
          if (byte_done) begin
            nxt_st.cnt = 4'h0;
            nxt_st.drive = 1'b1;
            if (st_ff.state == ST_CTRL) begin
              if (code_ok) begin
                nxt_st.state = ST_CTRL_ACK;
                nxt_st.rw = st_ff.shift[CB_RW_BIT];
                nxt_st.addr[10:8] =
                  st_ff.shift[CB_BLK_MSB:CB_BLK_LSB];
              end else begin
                nxt_st.state = ST_IGNORE;
                nxt_st.drive = 1'b0;
              end
            end else if (st_ff.state == ST_WADDR) begin
              nxt_st.state = ST_WADDR_ACK;
              nxt_st.addr[7:0] = st_ff.shift;
            end else begin
              nxt_st.state = ST_WDATA_ACK;
              // Successive bytes land at successive addresses
              nxt_st.addr = st_ff.addr + 11'h001;
              case (addr_sel(st_ff.addr))
                SEL_DUTY_LO: nxt_st.regs.duty_lo = st_ff.shift;
                SEL_DUTY_HI: nxt_st.regs.duty_hi = st_ff.shift;
                SEL_VIN: begin
                  nxt_st.regs.vin = st_ff.shift[1:0];
                end
                default: nxt_st.regs = st_ff.regs;
              endcase
            end
          end
        end
        ST_CTRL_ACK: begin
          if (scl_fall) begin
            nxt_st.cnt = 4'h0;
            if (st_ff.rw) begin
              nxt_st.state = ST_RDATA;
              nxt_st.shift = rd_byte;
              nxt_st.drive = ~rd_byte[7];
            end else begin
              nxt_st.state = ST_WADDR;
              nxt_st.drive = 1'b0;
            end
          end
        end
        ST_WADDR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_st.state = ST_WDATA;
            nxt_st.drive = 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (st_ff.cnt == LAST_BIT) begin
              nxt_st.state = ST_RDATA_ACK;
              nxt_st.drive = 1'b0;
              nxt_st.addr = st_ff.addr + 11'h001;
            end else begin
              nxt_st.shift = {st_ff.shift[6:0], 1'b0};
              nxt_st.drive = ~st_ff.shift[6];
              nxt_st.cnt = st_ff.cnt + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            nxt_st.nack = sda_s;
          end
          if (scl_fall) begin
            // A nack from the master ends the read until the next start
            if (st_ff.nack) begin
              nxt_st.state = ST_IGNORE;
            end else begin
              nxt_st.state = ST_RDATA;
              nxt_st.cnt = 4'h0;
              nxt_st.shift = rd_byte;
              nxt_st.drive = ~rd_byte[7];
            end
          end
        end
        default: begin
          nxt_st.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~st_ff.drive;
  assign output_state_zero_o = st_ff.regs.vin[VIN_OUTPUT_STATE_ZERO_BIT];
  assign output_state_one_o = st_ff.regs.vin[VIN_OUTPUT_STATE_ONE_BIT];
  assign switched_output_en_o = ~st_ff.regs.vin[VIN_OUTPUT_STATE_ONE_BIT];
  assign pwm_duty_o = {st_ff.regs.duty_hi, st_ff.regs.duty_lo};

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_ctrl_ack;
    (st_ff.state == ST_CTRL && byte_done && code_ok && !bus_start &&
     !bus_stop) |=> !sda_oe_n_o && st_ff.state == ST_CTRL_ACK;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack)
    else $error("control byte not acknowledged");

  property p_mismatch;
    (st_ff.state == ST_CTRL && byte_done && !code_ok && !bus_start &&
     !bus_stop) |=> sda_oe_n_o && st_ff.state == ST_IGNORE;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("foreign control code was acknowledged");

  property p_ignore_quiet;
    st_ff.state == ST_IGNORE |-> sda_oe_n_o;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet)
    else $error("SDA driven while ignoring");

  property p_block_bits;
    (st_ff.state == ST_CTRL && byte_done && code_ok && !bus_start &&
     !bus_stop) |=> st_ff.addr[10:8] == $past(st_ff.shift[3:1]) &&
     st_ff.rw == $past(st_ff.shift[0]);
  endproperty
  a_block_bits: assert property (p_block_bits)
    else $error("block bits or direction not captured");

  property p_word_addr;
    (st_ff.state == ST_WADDR && byte_done && !bus_start && !bus_stop) |=>
      st_ff.addr[7:0] == $past(st_ff.shift) && !sda_oe_n_o;
  endproperty
  a_word_addr: assert property (p_word_addr)
    else $error("word address not loaded and acknowledged");

  property p_commit;
    (wr_commit && !bus_start && !bus_stop && st_ff.addr == ADDR_DUTY_LO)
      |=> pwm_duty_o[7:0] == $past(st_ff.shift) && !sda_oe_n_o;
  endproperty
  a_commit: assert property (p_commit)
    else $error("data not committed at its acknowledge");

  property p_vin_write;
    (wr_commit && !bus_start && !bus_stop && st_ff.addr == ADDR_VIN) |=>
      output_state_zero_o == $past(st_ff.shift[0]) &&
      switched_output_en_o == !$past(st_ff.shift[1]);
  endproperty
  a_vin_write: assert property (p_vin_write)
    else $error("virtual inputs did not follow the write");

  property p_addr_inc;
    (wr_commit && !bus_start && !bus_stop) |=>
      st_ff.addr == $past(st_ff.addr) + 11'h001;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address pointer did not advance");

  property p_rstart;
    (bus_start && st_ff.state == ST_WDATA) |=>
      st_ff.state == ST_CTRL && st_ff.addr == $past(st_ff.addr) &&
      $stable(pwm_duty_o);
  endproperty
  a_rstart: assert property (p_rstart)
    else $error("repeated start did not abandon the write");

  property p_read_out;
    (st_ff.state == ST_CTRL_ACK && st_ff.rw && scl_fall && !bus_start &&
     !bus_stop) |=> st_ff.state == ST_RDATA &&
     sda_oe_n_o == $past(rd_byte[7]);
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("read data not shifted out after acknowledge");

  property p_vin_read;
    (st_ff.state == ST_CTRL_ACK && st_ff.rw && st_ff.addr == ADDR_VIN)
      |-> rd_byte == {6'h00, output_state_one_o, output_state_zero_o};
  endproperty
  a_vin_read: assert property (p_vin_read)
    else $error("virtual byte read returns wrong states");

  property p_duty_rst;
    $fell(sys_rst_i) |-> pwm_duty_o == {DUTY_HI_RST, DUTY_LO_RST};
  endproperty
  a_duty_rst: assert property (disable iff (1'b0) p_duty_rst)
    else $error("duty bytes not at reset default");

  c_write: cover property (wr_commit);
  c_rstart: cover property (bus_start && st_ff.state == ST_WDATA);
  c_read: cover property (st_ff.state == ST_RDATA_ACK && scl_fall);
  c_ignore: cover property (st_ff.state == ST_IGNORE);
endmodule

/* logic/ita_pkg.sv */
// Purpose: Shared constants and types of the I2C target config block
// Assumes: 100 MHz clock_i, synchronous active-high sys_rst_i
// Notes: Addresses are 11 bits, block address bits on top
package ita_pkg;
  localparam int CLK_MHZ = 100;
  localparam logic [10:0] ADDR_DUTY_LO = 11'h0C5;
  localparam logic [10:0] ADDR_DUTY_HI = 11'h0C6;
  localparam logic [10:0] ADDR_VIN = 11'h0F4;
  localparam logic [7:0] DUTY_LO_RST = 8'h65;
  localparam logic [7:0] DUTY_HI_RST = 8'h65;
  localparam logic [1:0] VIN_RST = 2'h0;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int VIN_OUTPUT_STATE_ZERO_BIT = 0;
  localparam int VIN_OUTPUT_STATE_ONE_BIT = 1;
  localparam int CB_RW_BIT = 0;
  localparam int CB_BLK_LSB = 1;
  localparam int CB_BLK_MSB = 3;
  localparam int CB_CODE_LSB = 4;
  localparam int CB_CODE_MSB = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] BUS_IDLE = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CTRL = 4'h1,
    ST_CTRL_ACK = 4'h3,
    ST_WADDR = 4'h2,
    ST_WADDR_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hC,
    ST_IGNORE = 4'hD
  } ita_state_e;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_DUTY_LO = 2'h1,
    SEL_DUTY_HI = 2'h2,
    SEL_VIN = 2'h3
  } ita_sel_e;

  typedef struct packed {
    logic [7:0] duty_lo;
    logic [7:0] duty_hi;
    logic [1:0] vin;
  } ita_regs_s;

  typedef struct packed {
    ita_state_e state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [10:0] addr;
    logic rw;
    logic nack;
    logic drive;
    logic scl_q;
    logic sda_q;
    ita_regs_s regs;
  } ita_core_s;

  localparam ita_core_s CORE_RST = '{
    state: ST_IDLE, cnt: 4'h0, shift: 8'h00, addr: 11'h000, rw: 1'b0,
    nack: 1'b0, drive: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
    regs: '{duty_lo: DUTY_LO_RST, duty_hi: DUTY_HI_RST, vin: VIN_RST}};

  typedef struct packed {
    logic [1:0] stg1;
    logic [1:0] stg2;
  } ita_sync_s;

  localparam ita_sync_s SYNC_RST = '{stg1: BUS_IDLE, stg2: BUS_IDLE};
endpackage

/* logic/ita_sync.sv */
// Purpose: Two-stage synchroniser for the SCL and SDA pins
// Assumes: Pins are asynchronous to clock_i
// Notes: Resets to the idle-high bus level
module ita_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Pins in, synced out
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_sync_o
);
  import ita_pkg::*;

  ita_sync_s st_ff;
  ita_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stg1 = pin_i;
    nxt_st.stg2 = st_ff.stg1;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= SYNC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_sync_o = st_ff.stg2;
endmodule

/* test/ita_bus_master.sv */
// Purpose: Behavioural I2C bus master driving the target's pins
// Assumes: SCL phases of 20 clocks, SDA pulled up outside
// Notes: SCL is driven push-pull since the target never stretches it
module ita_bus_master (
  // Clock
  input wire logic clock_i,
  // Resolved data line
  input wire logic sda_i,
  // Pins driven by the master
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 10;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Works from idle and as a repeated start after an ack bit
  task automatic start_cond();
    sda_low_o = 1'b0;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_low_o = 1'b1;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_low_o = 1'b0;
    tick(2 * Q);
  endtask

  // SDA only moves mid-low, well away from both SCL edges
  task automatic bit_cycle(input logic b, output logic got);
    sda_low_o = ~b;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    got = sda_i;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask

  // MSB first, then the ninth bit released for the target
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], g);
    end
    bit_cycle(1'b1, g);
    ack = ~g;
  endtask

  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic g;
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b1, g);
      d = {d[6:0], g};
    end
    bit_cycle(~ack_it, g);
  endtask
endmodule

/* test/tb_ita_top.sv */
// Purpose: Self-checking bench of the I2C target register block
// Assumes: ctrl_code_i is static during each transfer
// Notes: Reference model keeps the mapped bytes in an associative array
module tb_ita_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ita_pkg::*;

  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] ctrl_code_i = 4'h1;
  logic scl;
  logic sda_low;
  logic sda_res;
  logic sda_o;
  logic sda_oe_n_o;
  logic output_state_zero;
  logic output_state_one;
  logic sw_en;
  logic [15:0] pwm;
  int n_fail = 0;
  int tests_run = 0;
  int mem[int];
  logic [3:0] cfg;
  logic [7:0] rb;
  logic [7:0] r0;
  logic [7:0] r1;

  always #5 clock_i = ~clock_i;

  // Pull-up wins unless some party pulls low
  assign sda_res = (sda_low || (!sda_oe_n_o && !sda_o)) ? 1'b0 : 1'b1;

  ita_bus_master mst (.clock_i(clock_i), .sda_i(sda_res), .scl_o(scl),
    .sda_low_o(sda_low));

  ita_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ctrl_code_i(ctrl_code_i), .scl_i(scl), .sda_i(sda_res),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .output_state_zero_o(output_state_zero),
    .output_state_one_o(output_state_one), .switched_output_en_o(sw_en),
    .pwm_duty_o(pwm));

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  function automatic logic [7:0] model_rd(input int a);
    return mem.exists(a) ? 8'(mem[a]) : 8'h00;
  endfunction

  // Output pins follow the model's register bytes
  task automatic chk_outs();
    chk({14'h0000, output_state_one, output_state_zero}, 16'(mem[32'h0F4]));
    chk({15'h0000, sw_en}, {15'h0000, ~mem[32'h0F4][1]});
    chk(pwm, {model_rd(32'h0C6), model_rd(32'h0C5)});
  endtask

  // Write n bytes from a word address; outputs checked before the stop
  task automatic wr(input logic [3:0] code, input logic [2:0] blk,
                    input logic [7:0] wa, input logic [7:0] d0,
                    input logic [7:0] d1, input int n);
    logic ack;
    logic hit;
    logic [7:0] d;
    int a;
    hit = (code == cfg);
    a = {blk, wa};
    mst.start_cond();
    mst.send_byte({code, blk, 1'b0}, ack);
    chk({15'h0000, ack}, {15'h0000, hit});
    if (hit) begin
      mst.send_byte(wa, ack);
      chk({15'h0000, ack}, 16'h0001);
      for (int i = 0; i < n; i++) begin
        d = (i == 0) ? d0 : d1;
        mst.send_byte(d, ack);
        chk({15'h0000, ack}, 16'h0001);
        if (mem.exists(a)) begin
          mem[a] = (a == 32'h0F4) ? int'(d[1:0]) : int'(d);
        end
        a = (a + 1) % 2048;
      end
      chk_outs();
    end
    mst.stop_cond();
  endtask

  // Random read of n bytes: master ACKs all but the last, which it NACKs
  task automatic rd(input logic [2:0] blk, input logic [7:0] wa,
                    input int n);
    logic ack;
    int a;
    a = {blk, wa};
    mst.start_cond();
    mst.send_byte({cfg, blk, 1'b0}, ack);
    chk({15'h0000, ack}, 16'h0001);
    mst.send_byte(wa, ack);
    chk({15'h0000, ack}, 16'h0001);
    mst.start_cond();
    mst.send_byte({cfg, blk, 1'b1}, ack);
    chk({15'h0000, ack}, 16'h0001);
    for (int i = 0; i < n; i++) begin
      mst.recv_byte(i < n - 1, rb);
      chk({8'h00, rb}, {8'h00, model_rd(a)});
      a = (a + 1) % 2048;
    end
    mst.stop_cond();
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(93));
    cfg = 4'($urandom());
    mem[32'h0C5] = 32'h65;
    mem[32'h0C6] = 32'h65;
    mem[32'h0F4] = 0;
    repeat (4) @(posedge clock_i);
    #1;
    ctrl_code_i = cfg;
    sys_rst_i = 1'b0;
    mst.tick(4);
    chk_outs();
    $display("reset values done");
    for (int v = 0; v < 4; v++) begin
      r0 = {6'($urandom()), 2'(v)};
      wr(cfg, 3'h0, 8'hF4, r0, 8'h00, 1);
      rd(3'h0, 8'hF4, 1);
    end
    $display("virtual input writes done");
    r0 = 8'($urandom());
    r1 = 8'($urandom());
    wr(cfg, 3'h0, 8'hC5, r0, r1, 2);
    rd(3'h0, 8'hC5, 2);
    $display("duty write done");
    // Mid-run reset on an idle bus must restore every default
    sys_rst_i = 1'b1;
    mst.tick(2);
    sys_rst_i = 1'b0;
    mem[32'h0C5] = 32'h65;
    mem[32'h0C6] = 32'h65;
    mem[32'h0F4] = 0;
    mst.tick(4);
    chk_outs();
    $display("mid-run reset done");
    wr(cfg ^ 4'h5, 3'h0, 8'hF4, 8'h02, 8'h00, 1);
    chk_outs();
    $display("foreign code done");
    // Block bits move the address out of the mapped set
    wr(cfg, 3'h1, 8'hF4, 8'h02, 8'h00, 1);
    rd(3'h1, 8'hF4, 1);
    chk_outs();
    $display("block address done");
    give_verdict();
  end
endmodule
